// [core/anpr_regs.sv]
// Next-page exchange registers: expansion, local and partner pages, PLL
//
// Functional notes
// - Expansion reports local next-page ability, reads 1
// - Expansion shows partner auto-negotiation ability, reset 0
// - Local next-page flag writable, reset 0
// - Local message-page reset 1, comply flag reset 0
// - Local toggle mirrors last transmitted toggle value
// - Local 11-bit message code writable, reset one
// - Partner page stored read-only, reset zero
// - Partner message-page and ability-to-act in bits 13,12
// - Partner toggle bit reads inverted
// - Control bit lets PLL stop in energy-detect power-down
`timescale 1ns/1ps
`default_nettype none
module anpr_regs
	import anpr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Management register port
	input wire logic [ANPR_AW-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ANPR_DW-1:0] reg_wdata,
	output logic [ANPR_DW-1:0] reg_rdata,
	output logic reg_rvalid,
	// Local transmit side
	input wire logic tx_page_sent,
	input wire logic tx_toggle,
	output logic [ANPR_DW-1:0] np_tx_word,
	// Link partner side, asynchronous
	input wire logic [ANPR_DW-1:0] lp_page_word,
	input wire logic lp_page_toggle,
	input wire logic lp_an_able,
	// Power control
	input wire logic energy_detect_power_down,
	output logic pll_power_off
);
	anpr_state_t st_reg;
	anpr_state_t st_next;
	logic [ANPR_DW-1:0] lp_word_s;
	logic lp_tgl_s;
	logic lp_an_s;
	logic rx_evt;
	logic rd_exp;
	logic pll_want;
	logic [ANPR_DW-1:0] exp_val;
	logic [ANPR_DW-1:0] tx_val;

	// Partner word must be stable before its toggle flips
	anpr_sync #(.W(ANPR_DW + 2)) u_sync (
		.clk(clk),
		.resetn(resetn),
		.d({lp_page_word, lp_page_toggle, lp_an_able}),
		.q({lp_word_s, lp_tgl_s, lp_an_s})
	);

	assign rx_evt = lp_tgl_s ^ st_reg.rx_tgl_seen;
	assign rd_exp = reg_rd && (reg_addr == ANPR_OFF_EXP);
	assign pll_want = st_reg.dig_ctrl[ANPR_DIG_PLL_OFF] &
		energy_detect_power_down;

	always_comb
	begin
		exp_val = '0;
		exp_val[ANPR_EXP_NP_ABLE] = ANPR_NP_ABLE_VAL;
		exp_val[ANPR_EXP_PAGE_RX] = st_reg.page_rx;
		exp_val[ANPR_EXP_LP_AN] = st_reg.lp_an_able;
		tx_val = {st_reg.np_more, 1'h0, st_reg.np_msgpg, st_reg.np_ack2,
			st_reg.np_toggle, st_reg.np_msg};
	end

	always_comb
	begin
		st_next = st_reg;
		st_next.rvalid = reg_rd;
		st_next.lp_an_able = lp_an_s;
		st_next.rx_tgl_seen = lp_tgl_s;
		st_next.pll_off = pll_want;
		if (reg_rd)
		begin
			case (reg_addr)
				ANPR_OFF_EXP: st_next.rdata = exp_val;
				ANPR_OFF_NP_TX: st_next.rdata = tx_val;
				ANPR_OFF_NP_RX: st_next.rdata = st_reg.rx_word;
				ANPR_OFF_DIG: st_next.rdata = st_reg.dig_ctrl;
				ANPR_OFF_AFE: st_next.rdata = st_reg.afe_ctrl;
				default: st_next.rdata = '0;
			endcase
		end
		if (reg_wr)
		begin
			case (reg_addr)
				ANPR_OFF_NP_TX:
				begin
					st_next.np_more = reg_wdata[ANPR_NP_MORE];
					st_next.np_msgpg = reg_wdata[ANPR_NP_MSGPG];
					st_next.np_ack2 = reg_wdata[ANPR_NP_ACK2];
					st_next.np_msg = reg_wdata[ANPR_MSG_W-1:0];
				end
				ANPR_OFF_DIG: st_next.dig_ctrl = reg_wdata;
				ANPR_OFF_AFE: st_next.afe_ctrl = reg_wdata;
				default: st_next.afe_ctrl = st_reg.afe_ctrl;
			endcase
		end
		if (tx_page_sent)
			st_next.np_toggle = tx_toggle;
		// Clear on read first, so a page in the same cycle still sets
		if (rd_exp)
			st_next.page_rx = 1'h0;
		if (rx_evt)
		begin
			st_next.page_rx = 1'h1;
			st_next.rx_word = lp_word_s;
			st_next.rx_word[ANPR_NP_TOGGLE] =
				~lp_word_s[ANPR_NP_TOGGLE];
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_reg.np_more <= ANPR_RST_MORE;
			st_reg.np_msgpg <= ANPR_RST_MSGPG;
			st_reg.np_ack2 <= ANPR_RST_ACK2;
			st_reg.np_toggle <= 1'h0;
			st_reg.np_msg <= ANPR_RST_MSG;
			st_reg.rx_word <= ANPR_RST_RX;
			st_reg.page_rx <= 1'h0;
			st_reg.lp_an_able <= 1'h0;
			st_reg.rx_tgl_seen <= 1'h0;
			st_reg.dig_ctrl <= ANPR_RST_DIG;
			st_reg.afe_ctrl <= ANPR_RST_AFE;
			st_reg.rdata <= 16'h0000;
			st_reg.rvalid <= 1'h0;
			st_reg.pll_off <= 1'h0;
		end
		else
			st_reg <= st_next;
	end

	assign reg_rdata = st_reg.rdata;
	assign reg_rvalid = st_reg.rvalid;
	assign np_tx_word = {st_reg.np_more, 1'h0, st_reg.np_msgpg,
		st_reg.np_ack2, st_reg.np_toggle, st_reg.np_msg};
	assign pll_power_off = st_reg.pll_off;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_page_rx_set: assert property (rx_evt |=> st_reg.page_rx)
		else $error("page received not set after new page");
	a_page_rx_clear: assert property (
		rd_exp && !rx_evt ##1 !rx_evt |=> !st_reg.page_rx)
		else $error("page received not cleared by read");
	a_read_clears: assert property (
		rd_exp && !rx_evt |=> !st_reg.page_rx)
		else $error("page received survived expansion read");
	a_np_able_reads: assert property (
		rd_exp |=> reg_rvalid && reg_rdata[ANPR_EXP_NP_ABLE])
		else $error("next page able did not read 1");
	a_lp_an_report: assert property (
		rd_exp |=> reg_rdata[ANPR_EXP_LP_AN] == $past(st_reg.lp_an_able))
		else $error("partner autoneg ability misreported");
	a_np_flags_write: assert property (
		reg_wr && reg_addr == ANPR_OFF_NP_TX |=>
			np_tx_word[15:12] == {$past(reg_wdata[15]), 1'h0,
			$past(reg_wdata[13]), $past(reg_wdata[12])})
		else $error("next page flags not written");
	a_msg_write: assert property (
		reg_wr && reg_addr == ANPR_OFF_NP_TX |=>
			np_tx_word[10:0] == $past(reg_wdata[10:0]))
		else $error("message code not written");
	a_tx_toggle: assert property (
		tx_page_sent |=> np_tx_word[ANPR_NP_TOGGLE] == $past(tx_toggle))
		else $error("local toggle not tracking transmit");
	a_rx_capture: assert property (
		rx_evt |=> st_reg.rx_word[15:12] == $past(lp_word_s[15:12])
			&& st_reg.rx_word[10:0] == $past(lp_word_s[10:0]))
		else $error("partner page not captured");
	a_rx_toggle_inv: assert property (
		rx_evt |=> st_reg.rx_word[ANPR_NP_TOGGLE] !=
			$past(lp_word_s[ANPR_NP_TOGGLE]))
		else $error("partner toggle not inverted");
	a_pll_gate: assert property (
		##1 pll_power_off == $past(pll_want))
		else $error("pll power off not following control");

	c_page_rx: cover property (rx_evt ##1 rd_exp);
	c_rx_and_read: cover property (rx_evt && rd_exp);
	c_np_write: cover property (reg_wr && reg_addr == ANPR_OFF_NP_TX);
	c_pll_off: cover property (pll_power_off);
endmodule : anpr_regs
`default_nettype wire

// [core/anpr_sync.sv]
// Two-flop synchroniser for signals arriving from the link side
`timescale 1ns/1ps
`default_nettype none
module anpr_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_reg <= '0;
			q <= '0;
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : anpr_sync
`default_nettype wire

// [shared/anpr_pkg.sv]
// Constants for the auto-negotiation next-page register bank
package anpr_pkg;
	localparam int ANPR_AW = 5;
	localparam int ANPR_DW = 16;
	localparam logic [4:0] ANPR_OFF_EXP = 5'h06;
	localparam logic [4:0] ANPR_OFF_NP_TX = 5'h07;
	localparam logic [4:0] ANPR_OFF_NP_RX = 5'h08;
	localparam logic [4:0] ANPR_OFF_DIG = 5'h10;
	localparam logic [4:0] ANPR_OFF_AFE = 5'h11;
	localparam int ANPR_EXP_NP_ABLE = 2;
	localparam int ANPR_EXP_PAGE_RX = 1;
	localparam int ANPR_EXP_LP_AN = 0;
	localparam int ANPR_NP_MORE = 15;
	localparam int ANPR_NP_ACK = 14;
	localparam int ANPR_NP_MSGPG = 13;
	localparam int ANPR_NP_ACK2 = 12;
	localparam int ANPR_NP_TOGGLE = 11;
	localparam int ANPR_MSG_W = 11;
	localparam int ANPR_DIG_PLL_OFF = 4;
	localparam logic ANPR_NP_ABLE_VAL = 1'h1;
	localparam logic ANPR_RST_MORE = 1'h0;
	localparam logic ANPR_RST_MSGPG = 1'h1;
	localparam logic ANPR_RST_ACK2 = 1'h0;
	localparam logic [10:0] ANPR_RST_MSG = 11'h001;
	localparam logic [15:0] ANPR_RST_RX = 16'h0000;
	localparam logic [15:0] ANPR_RST_DIG = 16'h0000;
	localparam logic [15:0] ANPR_RST_AFE = 16'h0000;

	typedef struct packed {
		logic np_more;
		logic np_msgpg;
		logic np_ack2;
		logic np_toggle;
		logic [10:0] np_msg;
		logic [15:0] rx_word;
		logic page_rx;
		logic lp_an_able;
		logic rx_tgl_seen;
		logic [15:0] dig_ctrl;
		logic [15:0] afe_ctrl;
		logic [15:0] rdata;
		logic rvalid;
		logic pll_off;
	} anpr_state_t;
endpackage : anpr_pkg

// [verif/anpr_link_partner.sv]
// Behavioural remote link partner handing over next pages
`timescale 1ns/1ps
`default_nettype none
module anpr_link_partner (
	// Control from bench
	input wire logic clk,
	input wire logic send,
	input wire logic [15:0] word,
	// Link side
	output logic [15:0] lp_page_word,
	output logic lp_page_toggle
);
	initial
	begin
		lp_page_word = 16'h0000;
		lp_page_toggle = 1'b0;
	end
	// Word settles well before toggle flips, toggle alternates per page
	always
	begin
		@(posedge send);
		lp_page_word = {word[15:12], ~lp_page_toggle, word[10:0]};
		repeat (4) @(negedge clk);
		lp_page_toggle = ~lp_page_toggle;
	end
endmodule : anpr_link_partner
`default_nettype wire

// [verif/anpr_regs_test.sv]
// Self-checking bench for the next-page register bank
`timescale 1ns/1ps
`default_nettype none
module anpr_regs_test;
	import anpr_pkg::*;
	logic clk, resetn, reg_wr, reg_rd, tx_page_sent, tx_toggle;
	logic lp_an_able, energy_detect_power_down, reg_rvalid, pll_power_off;
	logic send, lp_page_toggle;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, np_tx_word, lp_page_word, word;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	anpr_regs i_anpr_regs (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.tx_page_sent(tx_page_sent), .tx_toggle(tx_toggle),
		.np_tx_word(np_tx_word), .lp_page_word(lp_page_word),
		.lp_page_toggle(lp_page_toggle), .lp_an_able(lp_an_able),
		.energy_detect_power_down(energy_detect_power_down),
		.pll_power_off(pll_power_off));
	anpr_link_partner i_anpr_link_partner (.clk(clk), .send(send),
		.word(word), .lp_page_word(lp_page_word),
		.lp_page_toggle(lp_page_toggle));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		// Idle cycle, so a following call never re-raises in one step
		@(negedge clk);
	endtask : wr
	// Answer lands one edge after the request, so check it at next fall
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		chk({15'h0000, reg_rvalid}, 16'h0001);
		chk(reg_rdata, exp);
		@(negedge clk);
	endtask : rd
	task automatic page(input logic [15:0] w);
		word = w;
		send = 1'b1;
		@(negedge clk);
		send = 1'b0;
		repeat (10) @(negedge clk);
	endtask : page
	task automatic results;
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			results();
		end
	end
	initial
	begin
		{resetn, reg_wr, reg_rd, tx_page_sent, tx_toggle, send} = 6'h00;
		{lp_an_able, energy_detect_power_down} = 2'h0;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		word = 16'h0000;
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		rd(ANPR_OFF_EXP, 16'h0004);
		rd(ANPR_OFF_NP_TX, 16'h2001);
		rd(ANPR_OFF_NP_RX, 16'h0000);
		rd(ANPR_OFF_DIG, 16'h0000);
		wr(ANPR_OFF_NP_TX, 16'hffff);
		rd(ANPR_OFF_NP_TX, 16'hb7ff);
		chk(np_tx_word, 16'hb7ff);
		tx_toggle = 1'b1;
		tx_page_sent = 1'b1;
		@(negedge clk);
		tx_page_sent = 1'b0;
		rd(ANPR_OFF_NP_TX, 16'hbfff);
		tx_toggle = 1'b0;
		tx_page_sent = 1'b1;
		@(negedge clk);
		tx_page_sent = 1'b0;
		rd(ANPR_OFF_NP_TX, 16'hb7ff);
		lp_an_able = 1'b1;
		page(16'hf055);
		rd(ANPR_OFF_NP_RX, 16'hf055);
		rd(ANPR_OFF_EXP, 16'h0007);
		rd(ANPR_OFF_EXP, 16'h0005);
		page(16'h20aa);
		wr(ANPR_OFF_NP_RX, 16'h1234);
		rd(ANPR_OFF_NP_RX, 16'h28aa);
		wr(ANPR_OFF_EXP, 16'hffff);
		rd(ANPR_OFF_EXP, 16'h0007);
		wr(5'h1f, 16'hffff);
		rd(5'h1f, 16'h0000);
		wr(ANPR_OFF_AFE, 16'hbeef);
		rd(ANPR_OFF_AFE, 16'hbeef);
		wr(ANPR_OFF_DIG, 16'h0010);
		// Control bit alone must not stop the PLL outside power-down
		repeat (2) @(negedge clk);
		chk({15'h0000, pll_power_off}, 16'h0000);
		energy_detect_power_down = 1'b1;
		repeat (2) @(negedge clk);
		chk({15'h0000, pll_power_off}, 16'h0001);
		wr(ANPR_OFF_DIG, 16'hffef);
		repeat (2) @(negedge clk);
		chk({15'h0000, pll_power_off}, 16'h0000);
		rd(ANPR_OFF_DIG, 16'hffef);
		// Mid-run reset must bring the next-page and digital control fields back
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		rd(ANPR_OFF_NP_TX, 16'h2001);
		rd(ANPR_OFF_DIG, 16'h0000);
		chk({15'h0000, pll_power_off}, 16'h0000);
		rd(ANPR_OFF_NP_RX, 16'h0000);
		rd(ANPR_OFF_EXP, 16'h0005);
		results();
	end
endmodule : anpr_regs_test
`default_nettype wire
